/* dms_peer.sv */
// Far-side serial peer: async line partner and listener on a master clock
`timescale 1ns/1ps
module dms_peer (
    input wire logic clk,
    input wire logic [3:0] pin_out,
    input wire logic [3:0] pin_oe,
    input wire logic [1:0] listen,
    input wire logic [15:0] bit_len,
    output logic [3:0] pin_in,
    output logic [9:0] got,
    output logic got_stb
);
    logic line_tx = 1'b1;
    logic ck_d = 1'b0;
    logic [9:0] sh = 10'h3ff;
    int n = 0;
    // Undriven pins sit on pull-ups; the peer drives serial input only
    assign pin_in = (pin_oe & pin_out) | (~pin_oe & {3'b111, line_tx});
    // Ten slots after a start bit, sampled mid-bit; or eight clock rises
    initial begin
        got_stb = 1'b0;
        got = 10'h000;
        forever begin
            @(posedge clk);
            got_stb <= 1'b0;
            if (listen == 2'b10 && pin_oe[2] && pin_out[2] && !ck_d) begin
                sh = {pin_out[1], sh[9:1]};
                n++;
                if (n == 8) begin
                    got <= {2'b11, sh[9:2]};
                    got_stb <= 1'b1;
                    n = 0;
                end
            end else if (listen == 2'b01 && !pin_out[1]) begin
                repeat (bit_len / 2) @(posedge clk);
                for (int i = 0; i < 10; i++) begin
                    repeat (bit_len) @(posedge clk);
                    sh[i] = pin_out[1];
                end
                got <= sh;
                got_stb <= 1'b1;
            end
            if (listen != 2'b10) n = 0;
            ck_d = pin_out[2];
        end
    end
    // Low start bit, ten slots LSB first, then idle high
    task automatic send(input logic [9:0] fr);
        line_tx <= 1'b0;
        repeat (bit_len) @(posedge clk);
        for (int i = 0; i < 10; i++) begin
            line_tx <= fr[i];
            repeat (bit_len) @(posedge clk);
        end
        line_tx <= 1'b1;
    endtask
endmodule

/* dms_pkg.sv */
// Package for the dual-mode serial port: offsets, modes, field layouts, reset values
package dms_pkg;

    // APB byte addresses
    localparam logic [7:0] DMS_CTRL_ADDR = 8'h00;
    localparam logic [7:0] DMS_DIR_ADDR = 8'h04;
    localparam logic [7:0] DMS_PORT_ADDR = 8'h08;
    localparam logic [7:0] DMS_TX_ADDR = 8'h0c;
    localparam logic [7:0] DMS_RX_ADDR = 8'h10;
    localparam logic [7:0] DMS_STAT_ADDR = 8'h14;

    typedef enum logic [1:0] {
        DMS_SYNC_MASTER = 2'b00,
        DMS_SYNC_SLAVE = 2'b01,
        DMS_ASYNC7 = 2'b10,
        DMS_ASYNC8 = 2'b11
    } dms_mode_t;

    typedef enum logic [1:0] {
        DMS_SRC_DIV16 = 2'b00,
        DMS_SRC_DIV8 = 2'b01,
        DMS_SRC_DIV4 = 2'b10,
        DMS_SRC_TIMER = 2'b11
    } dms_src_t;

    typedef enum logic [1:0] {
        DMS_IDLE = 2'b00,
        DMS_START = 2'b01,
        DMS_DATA = 2'b10,
        DMS_STOP = 2'b11
    } dms_state_t;

    // Control register layout, bit 7 downward
    typedef struct packed {
        logic osc_on;
        logic par_odd;
        logic par_en;
        dms_src_t clk_src;
        dms_mode_t xfer_mode;
        logic serial_pin_enable;
    } dms_ctrl_t;

    // Four shared pins, each as input, output and output enable
    typedef struct packed {
        logic [3:0] din;
        logic [3:0] dout;
        logic [3:0] oe;
    } dms_pins_t;

    localparam logic [7:0] DMS_CTRL_RESET = 8'h00;
    localparam logic [3:0] DMS_DIR_RESET = 4'h0;
    localparam logic [3:0] DMS_PORT_RESET = 4'hf;
    localparam logic [3:0] DMS_PH_LAST = 4'hf;
    localparam logic [3:0] DMS_PH_MID = 4'h7;
    localparam logic [3:0] DMS_SYNC_BITS = 4'h8;

    // Status register bit positions
    localparam int DMS_ST_TXBUSY = 0;
    localparam int DMS_ST_RXBUSY = 1;
    localparam int DMS_ST_RXFULL = 2;
    localparam int DMS_ST_PERR = 3;

    // Pin roles on the shared port
    localparam int DMS_PIN_SIN = 0;
    localparam int DMS_PIN_SERIAL_OUT_PIN = 1;
    localparam int DMS_PIN_SCLK = 2;
    localparam int DMS_PIN_RDY = 3;

endpackage

/* dms_serial.sv */
// Dual-mode serial port with shared port pins, APB register access
`timescale 1ns/1ps

module dms_serial
    import dms_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic [3:0] port_in,
    output logic [3:0] port_out,
    output logic [3:0] port_oe,
    input wire logic timer_underflow,
    output logic osc_enable
);

    dms_ctrl_t ctrl, next_ctrl;
    logic [3:0] dir, next_dir;
    logic [3:0] pdata, next_pdata;
    logic [31:0] next_prdata;
    logic [3:0] pre, next_pre;
    logic tmr_half, next_tmr_half;
    logic src_tick;
    // Sync engine
    logic s_busy, next_s_busy;
    logic [7:0] s_sh, next_s_sh;
    logic [3:0] s_cnt, next_s_cnt;
    logic [3:0] s_ph, next_s_ph;
    logic s_samp, next_s_samp;
    logic sclk_prev, next_sclk_prev;
    // Async transmit
    logic [10:0] t_sh, next_t_sh;
    logic [3:0] t_left, next_t_left;
    logic [3:0] t_os, next_t_os;
    // Async receive
    dms_state_t r_st, next_r_st;
    logic [8:0] r_sh, next_r_sh;
    logic [3:0] r_cnt, next_r_cnt;
    logic [3:0] r_os, next_r_os;
    logic [7:0] rx_buf, next_rx_buf;
    logic rx_full, next_rx_full;
    logic perr, next_perr;

    logic wr_en, rd_setup, is_async, is_slave, serial_in_pin, sclk_in;
    logic [3:0] nbits, ndata;
    logic cap_ev, sh_ev, sclk_out, serial_out_pin;
    logic [7:0] rdat;
    logic pbit;

    assign wr_en = psel & penable & pwrite;
    assign rd_setup = psel & ~penable & ~pwrite;
    assign is_async = ctrl.xfer_mode[1];
    assign is_slave = ctrl.xfer_mode == DMS_SYNC_SLAVE;
    assign serial_in_pin = port_in[DMS_PIN_SIN];
    assign sclk_in = port_in[DMS_PIN_SCLK];
    assign ndata = (ctrl.xfer_mode == DMS_ASYNC8) ? 4'h8 : 4'h7;
    assign nbits = ndata + {3'h0, ctrl.par_en};
    assign osc_enable = ctrl.osc_on;
    // Zero-wait slave: read data is latched in the setup cycle
    assign pready = 1'b1;
    assign pslverr = psel & penable & (paddr > DMS_STAT_ADDR || paddr[1:0] != 2'b00);

    // Source tick: oscillator prescale or halved timer underflow
    always_comb begin
        next_pre = ctrl.osc_on ? pre + 4'h1 : 4'h0;
        next_tmr_half = tmr_half ^ timer_underflow;
        case (ctrl.clk_src)
            DMS_SRC_DIV16: src_tick = ctrl.osc_on & (pre == 4'hf);
            DMS_SRC_DIV8: src_tick = ctrl.osc_on & (pre[2:0] == 3'h7);
            DMS_SRC_DIV4: src_tick = ctrl.osc_on & (pre[1:0] == 2'h3);
            DMS_SRC_TIMER: src_tick = timer_underflow & tmr_half;
            default: src_tick = 1'b0;
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pre <= 4'h0;
            tmr_half <= 1'b0;
        end else begin
            pre <= next_pre;
            tmr_half <= next_tmr_half;
        end
    end

    // Sync edge events: master from phase counter, slave from pin edges
    always_comb begin
        if (is_slave) begin
            cap_ev = s_busy & sclk_in & ~sclk_prev;
            sh_ev = s_busy & ~sclk_in & sclk_prev;
        end else begin
            cap_ev = s_busy & src_tick & (s_ph == DMS_PH_MID);
            sh_ev = s_busy & src_tick & (s_ph == DMS_PH_LAST);
        end
        sclk_out = ~(s_busy & ~s_ph[3]); // Idles high, low first half
        serial_out_pin = is_async ? (t_left != 4'h0 ? t_sh[0] : 1'b1) : s_sh[0];
    end

    // Register file, sync engine and async engines
    always_comb begin
        next_ctrl = ctrl;
        next_dir = dir;
        next_pdata = pdata;
        next_s_busy = s_busy;
        next_s_sh = s_sh;
        next_s_cnt = s_cnt;
        next_s_ph = s_ph;
        next_s_samp = s_samp;
        next_sclk_prev = sclk_in;
        next_t_sh = t_sh;
        next_t_left = t_left;
        next_t_os = t_os;
        next_r_st = r_st;
        next_r_sh = r_sh;
        next_r_cnt = r_cnt;
        next_r_os = r_os;
        next_rx_buf = rx_buf;
        next_rx_full = rx_full;
        next_perr = perr;
        rdat = 8'h00;
        pbit = 1'b0;
        // Bus writes; the status register takes write-one commands
        if (wr_en) begin
            case (paddr)
                DMS_CTRL_ADDR: next_ctrl = dms_ctrl_t'(pwdata[7:0]);
                DMS_DIR_ADDR: next_dir = pwdata[3:0];
                DMS_PORT_ADDR: next_pdata = pwdata[3:0];
                DMS_TX_ADDR: begin
                    if (!is_async && !s_busy) begin
                        next_s_sh = pwdata[7:0];
                        next_s_busy = 1'b1;
                        next_s_cnt = 4'h0;
                        next_s_ph = 4'h0;
                    end else if (is_async && t_left == 4'h0) begin
                        pbit = (^pwdata[7:0] & ndata[3]) ^ (^pwdata[6:0] & ~ndata[3])
                            ^ ctrl.par_odd;
                        if (ndata[3]) begin
                            next_t_sh = ctrl.par_en ? {1'b1, pbit, pwdata[7:0], 1'b0}
                                : {1'b1, 1'b1, pwdata[7:0], 1'b0};
                        end else begin
                            next_t_sh = ctrl.par_en ? {1'b1, 1'b1, pbit, pwdata[6:0], 1'b0}
                                : {1'b1, 1'b1, 1'b1, pwdata[6:0], 1'b0};
                        end
                        next_t_left = nbits + 4'h2;
                        next_t_os = 4'h0;
                    end
                end
                DMS_STAT_ADDR: begin
                    if (pwdata[DMS_ST_RXFULL]) begin
                        next_rx_full = 1'b0;
                        // Sync receive start reuses the shift register contents
                        if (!is_async && !s_busy) begin
                            next_s_busy = 1'b1;
                            next_s_cnt = 4'h0;
                            next_s_ph = 4'h0;
                        end
                    end
                    if (pwdata[DMS_ST_PERR]) begin
                        next_perr = 1'b0;
                    end
                end
                default: ;
            endcase
        end
        // Sync engine: eight bits, LSB first, capture on rise, shift on fall
        if (!is_async && s_busy) begin
            if (src_tick && !is_slave) begin
                next_s_ph = s_ph + 4'h1;
            end
            if (cap_ev) begin
                next_s_samp = serial_in_pin;
            end
            if (sh_ev) begin
                next_s_sh = {s_samp, s_sh[7:1]};
                next_s_cnt = s_cnt + 4'h1;
                if (s_cnt == DMS_SYNC_BITS - 4'h1) begin
                    next_s_busy = 1'b0;
                    next_rx_buf = {s_samp, s_sh[7:1]};
                    next_rx_full = 1'b1;
                end
            end
        end
        // Async transmitter, independent of the receiver
        if (is_async && t_left != 4'h0 && src_tick) begin
            next_t_os = t_os + 4'h1;
            if (t_os == DMS_PH_LAST) begin
                next_t_sh = {1'b1, t_sh[10:1]};
                next_t_left = t_left - 4'h1;
            end
        end
        // Async receiver with sixteen-times oversampling
        if (is_async && src_tick) begin
            next_r_os = r_os + 4'h1;
            case (r_st)
                DMS_IDLE: begin
                    next_r_os = 4'h0;
                    if (!serial_in_pin) begin
                        next_r_st = DMS_START;
                    end
                end
                DMS_START: begin
                    if (r_os == DMS_PH_MID) begin
                        next_r_os = 4'h0;
                        next_r_cnt = 4'h0;
                        next_r_st = serial_in_pin ? DMS_IDLE : DMS_DATA;
                    end
                end
                DMS_DATA: begin
                    if (r_os == DMS_PH_LAST) begin
                        next_r_sh = {serial_in_pin, r_sh[8:1]};
                        next_r_cnt = r_cnt + 4'h1;
                        if (r_cnt == nbits - 4'h1) begin
                            next_r_st = DMS_STOP;
                        end
                    end
                end
                DMS_STOP: begin
                    if (r_os == DMS_PH_LAST) begin
                        next_r_st = DMS_IDLE;
                        rdat = 8'(r_sh >> (4'h9 - nbits));
                        next_rx_buf = ndata[3] ? rdat : {1'b0, rdat[6:0]};
                        next_rx_full = 1'b1;
                        // Parity is the last slot shifted in, so it sits at the top
                        pbit = r_sh[8];
                        if (ctrl.par_en && (((^next_rx_buf) ^ pbit) != ctrl.par_odd)) begin
                            next_perr = 1'b1;
                        end
                    end
                end
                default: next_r_st = DMS_IDLE;
            endcase
        end else if (!is_async) begin
            next_r_st = DMS_IDLE;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl <= dms_ctrl_t'(DMS_CTRL_RESET);
            dir <= DMS_DIR_RESET;
            pdata <= DMS_PORT_RESET;
            s_busy <= 1'b0;
            s_sh <= 8'h00;
            s_cnt <= 4'h0;
            s_ph <= 4'h0;
            s_samp <= 1'b0;
            sclk_prev <= 1'b1;
            t_sh <= 11'h7ff;
            t_left <= 4'h0;
            t_os <= 4'h0;
            r_st <= DMS_IDLE;
            r_sh <= 9'h000;
            r_cnt <= 4'h0;
            r_os <= 4'h0;
            rx_buf <= 8'h00;
            rx_full <= 1'b0;
            perr <= 1'b0;
        end else begin
            ctrl <= next_ctrl;
            dir <= next_dir;
            pdata <= next_pdata;
            s_busy <= next_s_busy;
            s_sh <= next_s_sh;
            s_cnt <= next_s_cnt;
            s_ph <= next_s_ph;
            s_samp <= next_s_samp;
            sclk_prev <= next_sclk_prev;
            t_sh <= next_t_sh;
            t_left <= next_t_left;
            t_os <= next_t_os;
            r_st <= next_r_st;
            r_sh <= next_r_sh;
            r_cnt <= next_r_cnt;
            r_os <= next_r_os;
            rx_buf <= next_rx_buf;
            rx_full <= next_rx_full;
            perr <= next_perr;
        end
    end

    // Pin mux: general port unless the pin has a serial role in this mode
    always_comb begin
        port_out = pdata;
        port_oe = dir;
        if (ctrl.serial_pin_enable) begin
            port_oe[DMS_PIN_SIN] = 1'b0;
            port_oe[DMS_PIN_SERIAL_OUT_PIN] = 1'b1;
            port_out[DMS_PIN_SERIAL_OUT_PIN] = serial_out_pin;
            if (ctrl.xfer_mode == DMS_SYNC_MASTER) begin
                port_oe[DMS_PIN_SCLK] = 1'b1;
                port_out[DMS_PIN_SCLK] = sclk_out;
            end else if (is_slave) begin
                port_oe[DMS_PIN_SCLK] = 1'b0;
                port_oe[DMS_PIN_RDY] = 1'b1;
                port_out[DMS_PIN_RDY] = ~s_busy; // Active high ready
            end
        end
    end

    // Read data latched in the setup cycle
    always_comb begin
        next_prdata = prdata;
        if (rd_setup) begin
            case (paddr)
                DMS_CTRL_ADDR: next_prdata = {24'h00_0000, ctrl};
                DMS_DIR_ADDR: next_prdata = {28'h000_0000, dir};
                DMS_PORT_ADDR: next_prdata = {28'h000_0000, (dir & pdata) | (~dir & port_in)};
                DMS_TX_ADDR: next_prdata = {24'h00_0000, s_sh};
                DMS_RX_ADDR: next_prdata = {24'h00_0000, rx_buf};
                DMS_STAT_ADDR: next_prdata = {28'h000_0000, perr, rx_full,
                    s_busy | (r_st != DMS_IDLE), s_busy | (t_left != 4'h0)};
                default: next_prdata = 32'h0000_0000;
            endcase
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h0000_0000;
        end else begin
            prdata <= next_prdata;
        end
    end

endmodule

/* dms_serial_sva.sv */
// Port assertions for the dual-mode serial port
`timescale 1ns/1ps
module dms_serial_sva
    import dms_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic [3:0] port_in,
    input wire logic [3:0] port_out,
    input wire logic [3:0] port_oe,
    input wire logic timer_underflow,
    input wire logic osc_enable
);
    dms_ctrl_t ctrl, next_ctrl;
    logic [3:0] dir, next_dir;
    logic [7:0] hi, next_hi;
    logic acc, en;
    assign acc = psel && penable;
    assign en = ctrl.serial_pin_enable;
    // Shadow of control and direction; count of clock-pin high cycles
    always_comb begin
        next_ctrl = ctrl;
        next_dir = dir;
        if (acc && pwrite && paddr == DMS_CTRL_ADDR) next_ctrl = dms_ctrl_t'(pwdata[7:0]);
        if (acc && pwrite && paddr == DMS_DIR_ADDR) next_dir = pwdata[3:0];
        next_hi = port_out[DMS_PIN_SCLK] ? hi + 8'h01 : 8'h00;
    end
    // Registered at the same edge as the write, so both sides agree
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl <= dms_ctrl_t'(DMS_CTRL_RESET);
            dir <= DMS_DIR_RESET;
            hi <= 8'h00;
        end else begin
            ctrl <= next_ctrl;
            dir <= next_dir;
            hi <= next_hi;
        end
    end
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    sequence s_ctrl_wr;
        acc && pwrite && paddr == DMS_CTRL_ADDR;
    endsequence
    // Guard on the old level keeps a long idle-high span out of the count
    sequence s_clk_fall;
        en && ctrl.xfer_mode == DMS_SYNC_MASTER && ctrl.clk_src == DMS_SRC_DIV4
            && $fell(port_out[DMS_PIN_SCLK]) && !$past(port_out[DMS_PIN_SCLK], 40);
    endsequence
    sequence s_tx_fall;
        en && ctrl.xfer_mode[1] && $fell(port_out[DMS_PIN_SERIAL_OUT_PIN]);
    endsequence
    a_general_pins: assert property (!en |-> port_oe == dir)
        else $error("pin enables differ from direction");
    a_async_pins: assert property (en && ctrl.xfer_mode[1] |-> port_oe == {dir[3:2], 2'b10})
        else $error("async pin enables wrong");
    a_master_pins: assert property (en && ctrl.xfer_mode == DMS_SYNC_MASTER
        |-> port_oe == {dir[3], 3'b110})
        else $error("master pin enables wrong");
    a_slave_pins: assert property (en && ctrl.xfer_mode == DMS_SYNC_SLAVE
        |-> port_oe == 4'b1010)
        else $error("slave pin enables wrong");
    a_bit_high: assert property (s_clk_fall |-> hi == 8'h20)
        else $error("clock pin high phase length wrong");
    a_tx_bit_len: assert property (s_tx_fall |-> !port_out[DMS_PIN_SERIAL_OUT_PIN] [*8])
        else $error("serial output bit too short");
    a_reset_state: assert property ($rose(presetn) |-> !osc_enable && port_oe == 4'h0)
        else $error("reset state of pins or oscillator wrong");
    a_osc_follow: assert property (s_ctrl_wr |=> osc_enable == $past(pwdata[7]))
        else $error("oscillator enable does not follow control");
    a_bus_error: assert property (acc && (paddr > DMS_STAT_ADDR || paddr[1:0] != 2'b00)
        |-> pslverr && pready && (pwrite || prdata == 32'h0000_0000))
        else $error("bad address not refused");
    a_bus_ok: assert property (acc && paddr <= DMS_STAT_ADDR && paddr[1:0] == 2'b00 |-> !pslverr)
        else $error("good address refused");
endmodule

bind dms_serial dms_serial_sva u_sva (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
    .pwdata, .prdata, .pready, .pslverr, .port_in, .port_out, .port_oe, .timer_underflow,
    .osc_enable);

/* tb.sv */
// Self-checking bench for the dual-mode serial port
`timescale 1ns/1ps
module tb import dms_pkg::*;;
    logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic timer_underflow = 1'b0, tmr_on = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0000_0000, prdata;
    logic pready, pslverr, osc_enable, got_stb;
    logic [3:0] port_in, port_out, port_oe;
    logic [9:0] got;
    logic [1:0] listen = 2'b00;
    logic [15:0] bit_len = 16'h0040;
    int n_errors = 0, n_compared = 0;
    logic [32:0] rd_q[$];
    logic [9:0] rx_q[$];
    always #12.5 pclk = ~pclk;
    // Timer underflow every second cycle gives a source tick every fourth
    always @(posedge pclk) timer_underflow <= tmr_on && !timer_underflow;
    dms_serial dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
        .pready, .pslverr, .port_in, .port_out, .port_oe, .timer_underflow, .osc_enable);
    dms_peer peer (.clk(pclk), .pin_out(port_out), .pin_oe(port_oe), .listen, .bit_len,
        .pin_in(port_in), .got, .got_stb);
    task automatic check(input logic [32:0] seen, input logic [32:0] exp);
        n_compared++;
        if (seen !== exp) begin
            n_errors++;
            $display("unexpected at %0t: saw %h want %h", $time, seen, exp);
        end
    endtask
    task automatic close_out();
        $display("compared %0d errors %0d", n_compared, n_errors);
        if (n_errors == 0 && n_compared > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        psel <= 1'b1; penable <= 1'b0; pwrite <= wr; paddr <= a; pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) @(posedge pclk);
        psel <= 1'b0; penable <= 1'b0;
        @(posedge pclk);
    endtask
    task automatic rd(input logic [7:0] a, input logic [32:0] exp);
        rd_q.push_back(exp);
        apb(1'b0, a, 32'h0000_0000);
    endtask
    // Waits for the peer to report every frame still expected
    task automatic drain();
        for (int t = 0; t < 4000 && rx_q.size() != 0; t++) @(posedge pclk);
        repeat (64) @(posedge pclk);
        check(33'(rx_q.size()), 33'h0);
    endtask
    function automatic logic [3:0] exp_oe(input dms_ctrl_t c, input logic [3:0] dv);
        if (!c.serial_pin_enable) return dv;
        if (c.xfer_mode == DMS_SYNC_MASTER) return {dv[3], 3'b110};
        if (c.xfer_mode == DMS_SYNC_SLAVE) return 4'b1010;
        return {dv[3:2], 2'b10};
    endfunction
    // Data LSB first, optional parity, stop, idle padding
    function automatic logic [9:0] frame(input logic [7:0] d, input dms_ctrl_t c);
        logic p;
        p = ^(c.xfer_mode[0] ? d : {1'b0, d[6:0]}) ^ c.par_odd;
        if (!c.par_en) return c.xfer_mode[0] ? {2'b11, d} : {3'b111, d[6:0]};
        return c.xfer_mode[0] ? {1'b1, p, d} : {2'b11, p, d[6:0]};
    endfunction
    // Results arrive in request order; oldest note first
    always @(posedge pclk) begin
        if (psel && penable && pready && !pwrite) check({pslverr, prdata}, rd_q.pop_front());
        if (got_stb) check({23'h0, got}, {23'h0, rx_q.pop_front()});
    end
    initial begin
        repeat (40000) @(posedge pclk);
        n_errors++;
        close_out();
    end
    initial begin
        dms_ctrl_t c;
        logic [7:0] d;
        logic [3:0] dv, pd;
        logic bad;
        void'($urandom(43305));
        repeat (5) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        check({28'h0, port_oe, osc_enable}, 33'h0);
        rd(DMS_CTRL_ADDR, {25'h0, DMS_CTRL_RESET});
        rd(8'h18, {1'b1, 32'h0});
        rd(8'h06, {1'b1, 32'h0});
        apb(1'b1, 8'h1c, 32'h0000_00ff);
        // Pin ownership across every mode, serial off and on
        for (int k = 0; k < 8; k++) begin
            dv = 4'($urandom());
            pd = 4'($urandom());
            c = '0;
            c.serial_pin_enable = k[2];
            c.xfer_mode = dms_mode_t'(k[1:0]);
            apb(1'b1, DMS_DIR_ADDR, {28'h0, dv});
            apb(1'b1, DMS_PORT_ADDR, {28'h0, pd});
            apb(1'b1, DMS_CTRL_ADDR, {24'h0, c});
            check({29'h0, port_oe}, {29'h0, exp_oe(c, dv)});
            if (!k[2]) rd(DMS_PORT_ADDR, {29'h0, (dv & pd) | ~dv});
        end
        apb(1'b1, DMS_DIR_ADDR, 32'h0000_0000);
        // Each source and frame format, both directions at once
        for (int s = 0; s < 4; s++) begin
            c = '0;
            c.serial_pin_enable = 1'b1;
            c.osc_on = 1'b1;
            c.xfer_mode = s[0] ? DMS_ASYNC7 : DMS_ASYNC8;
            c.clk_src = dms_src_t'(s);
            c.par_en = s[1];
            c.par_odd = s[0];
            bad = (s == 2);
            bit_len = (s == 3) ? 16'h0040 : 16'(256 >> s);
            tmr_on = (s == 3);
            apb(1'b1, DMS_CTRL_ADDR, {24'h0, c});
            repeat (200) @(posedge pclk);
            listen = 2'b01;
            d = 8'($urandom());
            rx_q.push_back(frame(d, c));
            fork
                apb(1'b1, DMS_TX_ADDR, {24'h0, d});
                peer.send(frame(~d, c) ^ {1'b0, bad, 8'h00});
            join
            drain();
            rd(DMS_RX_ADDR, {25'h0, s[0] ? {1'b0, ~d[6:0]} : ~d});
            rd(DMS_STAT_ADDR, {29'h0, bad, 3'b100});
            apb(1'b1, DMS_STAT_ADDR, 32'h0000_000c);
            listen = 2'b00;
        end
        c = '0;
        c.serial_pin_enable = 1'b1;
        c.osc_on = 1'b1;
        c.clk_src = DMS_SRC_DIV4;
        tmr_on = 1'b0;
        apb(1'b1, DMS_CTRL_ADDR, {24'h0, c});
        listen = 2'b10;
        d = 8'($urandom());
        rx_q.push_back({2'b11, d});
        apb(1'b1, DMS_TX_ADDR, {24'h0, d});
        drain();
        rd(DMS_STAT_ADDR, 33'h4);
        close_out();
    end
endmodule
